// ==== design/itrb_sync2.sv ====
`timescale 1ns/100ps
module itrb_sync2 (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] d,
	output logic [1:0] q
);
	logic [1:0] meta_reg;
	logic [1:0] q_reg;

	// Resets to idle bus levels so no false start is seen at release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= itrb_pkg::PIN_IDLE;
			q_reg <= itrb_pkg::PIN_IDLE;
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule // itrb_sync2

// ==== design/itrb_top.sv ====
`timescale 1ns/100ps
module itrb_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl,
	input wire logic sda,
	output logic sda_level,
	output logic sda_oe,
	output logic [1:0] luma_delay_sel,
	output logic chroma_delay_en,
	output logic chroma_avg_en,
	output logic [1:0] color_kill_level,
	output logic awb_center_only,
	output logic awb_smart_en,
	output logic awb_seed_en,
	output logic [4:0] agc_max_gain_db,
	output logic agc_step_eighth,
	output logic pump_en,
	output logic [2:0] pump_drive,
	output logic vsync_drop_suppress,
	output logic dark_offset_neg,
	output logic [5:0] dark_offset_mag,
	output logic signed [6:0] dark_offset_value,
	output logic smart_color_en,
	output logic [6:0] sat_floor_pct,
	output logic [1:0] awb_chroma_min,
	output logic [1:0] awb_chroma_max
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
	} itrb_state_e;

	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [1:0] pin_sync;
	logic [1:0] pin_prev_reg;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	itrb_state_e state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] rx_reg;
	logic [7:0] tx_reg;
	logic [7:0] sub_reg;
	logic rw_reg;
	logic mack_reg;
	logic sda_oe_reg;
	logic wr_stb;
	logic [7:0] rd_data;
	logic [7:0] bank [itrb_pkg::NREG];
	logic [7:0] cl;
	logic [7:0] wb;
	logic [7:0] cp;
	logic [7:0] dof;
	logic [7:0] sa;
	logic [7:0] ch;
	logic [6:0] mag_ext;

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	itrb_sync2 u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({scl, sda}),
		.q(pin_sync)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev_reg <= itrb_pkg::PIN_IDLE;
		end else begin
			pin_prev_reg <= pin_sync;
		end
	end

	assign scl_s = pin_sync[1];
	assign sda_s = pin_sync[0];
	assign scl_rise = scl_s & ~pin_prev_reg[1];
	assign scl_fall = ~scl_s & pin_prev_reg[1];
	// Data may only change while the clock is low, so these mark framing
	assign start_det = scl_s & pin_prev_reg[1] & pin_prev_reg[0] & ~sda_s;
	assign stop_det = scl_s & pin_prev_reg[1] & ~pin_prev_reg[0] & sda_s;

	////////////////////////////////////////////////////////////////////////////
	// Serial control bus slave

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_reg <= 8'h00;
		end else if (scl_rise) begin
			rx_reg <= {rx_reg[6:0], sda_s};
		end
	end

	assign wr_stb = scl_fall && state_reg == ST_WDATA && bit_cnt_reg == itrb_pkg::BYTE_BITS;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			tx_reg <= 8'h00;
			sub_reg <= 8'h00;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (start_det) begin
			state_reg <= ST_ADDR;
			bit_cnt_reg <= 4'h0;
			sda_oe_reg <= 1'b0;
		end else if (stop_det) begin
			state_reg <= ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else if (scl_rise) begin
			case (state_reg)
				ST_ADDR, ST_SUB, ST_WDATA, ST_RDATA: begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				ST_RACK: begin
					mack_reg <= ~sda_s;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				ST_ADDR: begin
					if (bit_cnt_reg == itrb_pkg::BYTE_BITS) begin
						if (rx_reg[7:1] == itrb_pkg::DEV_ADDR) begin
							state_reg <= ST_ADDR_ACK;
							rw_reg <= rx_reg[0];
							sda_oe_reg <= 1'b1;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					bit_cnt_reg <= 4'h0;
					if (rw_reg) begin
						state_reg <= ST_RDATA;
						sda_oe_reg <= ~rd_data[7];
						tx_reg <= {rd_data[6:0], 1'b0};
					end else begin
						state_reg <= ST_SUB;
						sda_oe_reg <= 1'b0;
					end
				end
				ST_SUB: begin
					if (bit_cnt_reg == itrb_pkg::BYTE_BITS) begin
						sub_reg <= rx_reg;
						state_reg <= ST_SUB_ACK;
						sda_oe_reg <= 1'b1;
					end
				end
				ST_WDATA: begin
					if (bit_cnt_reg == itrb_pkg::BYTE_BITS) begin
						sub_reg <= sub_reg + 8'h01;
						state_reg <= ST_WDATA_ACK;
						sda_oe_reg <= 1'b1;
					end
				end
				ST_SUB_ACK, ST_WDATA_ACK: begin
					state_reg <= ST_WDATA;
					bit_cnt_reg <= 4'h0;
					sda_oe_reg <= 1'b0;
				end
				ST_RDATA: begin
					if (bit_cnt_reg == itrb_pkg::BYTE_BITS) begin
						sub_reg <= sub_reg + 8'h01;
						state_reg <= ST_RACK;
						sda_oe_reg <= 1'b0;
					end else begin
						sda_oe_reg <= ~tx_reg[7];
						tx_reg <= {tx_reg[6:0], 1'b0};
					end
				end
				ST_RACK: begin
					if (mack_reg) begin
						state_reg <= ST_RDATA;
						bit_cnt_reg <= 4'h0;
						sda_oe_reg <= ~rd_data[7];
						tx_reg <= {rd_data[6:0], 1'b0};
					end else begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Open-drain: only ever pulls low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_level <= 1'b0;
		end else begin
			sda_level <= 1'b0;
		end
	end

	assign sda_oe = sda_oe_reg;

	////////////////////////////////////////////////////////////////////////////
	// Register bank

	// Reserved bytes are stored whole, so whatever the host wrote reads back
	genvar g;
	generate
		for (g = 0; g < itrb_pkg::NREG; g++) begin : g_reg
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					bank[g] <= itrb_pkg::REG_RST[g];
				end else if (wr_stb && sub_reg == itrb_pkg::REG_OFFS[g]) begin
					bank[g] <= rx_reg;
				end
			end
		end
	endgenerate

	// Unmapped offsets read zero and ignore writes
	always_comb begin
		rd_data = 8'h00;
		for (int i = 0; i < itrb_pkg::NREG; i++) begin
			if (sub_reg == itrb_pkg::REG_OFFS[i]) begin
				rd_data = bank[i];
			end
		end
	end

	assign cl = bank[itrb_pkg::IX_CL];
	assign wb = bank[itrb_pkg::IX_WB];
	assign cp = bank[itrb_pkg::IX_CP];
	assign dof = bank[itrb_pkg::IX_DO];
	assign sa = bank[itrb_pkg::IX_SA];
	assign ch = bank[itrb_pkg::IX_CH];
	assign mag_ext = {1'b0, dof[itrb_pkg::MAG_H:itrb_pkg::MAG_L]};

	////////////////////////////////////////////////////////////////////////////
	// Field outputs to the processing datapaths

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			luma_delay_sel <= 2'h0;
			chroma_delay_en <= 1'b0;
			chroma_avg_en <= 1'b0;
			color_kill_level <= 2'h0;
			awb_center_only <= 1'b0;
			awb_smart_en <= 1'b0;
			awb_seed_en <= itrb_pkg::RST_WB[itrb_pkg::WB_SEED];
			agc_max_gain_db <= itrb_pkg::G12;
			agc_step_eighth <= 1'b0;
			pump_en <= itrb_pkg::RST_CP[itrb_pkg::CP_EN];
			pump_drive <= 3'h0;
			vsync_drop_suppress <= 1'b0;
			dark_offset_neg <= 1'b0;
			dark_offset_mag <= 6'h00;
			dark_offset_value <= 7'h00;
			smart_color_en <= 1'b0;
			sat_floor_pct <= itrb_pkg::SAT_HI;
			awb_chroma_min <= 2'h0;
			awb_chroma_max <= 2'h0;
		end else begin
			luma_delay_sel <= cl[itrb_pkg::LY_H:itrb_pkg::LY_L];
			chroma_delay_en <= cl[itrb_pkg::CL_UVD];
			chroma_avg_en <= cl[itrb_pkg::CL_AVG];
			color_kill_level <= cl[itrb_pkg::KL_H:itrb_pkg::KL_L];
			awb_center_only <= wb[itrb_pkg::WB_CTR];
			awb_smart_en <= wb[itrb_pkg::WB_SMART];
			awb_seed_en <= wb[itrb_pkg::WB_SEED];
			// Codes 00 and 10 alias to the same 6dB ceiling
			case (wb[itrb_pkg::AG_H:itrb_pkg::AG_L])
				itrb_pkg::AG_6A, itrb_pkg::AG_6B: agc_max_gain_db <= itrb_pkg::G6;
				itrb_pkg::AG_12: agc_max_gain_db <= itrb_pkg::G12;
				default: agc_max_gain_db <= itrb_pkg::G18;
			endcase
			agc_step_eighth <= &wb[itrb_pkg::AG_H:itrb_pkg::AG_L];
			pump_en <= cp[itrb_pkg::CP_EN];
			pump_drive <= cp[itrb_pkg::DRV_H:itrb_pkg::DRV_L];
			vsync_drop_suppress <= cp[itrb_pkg::CP_VS];
			dark_offset_neg <= dof[itrb_pkg::DO_SGN];
			dark_offset_mag <= dof[itrb_pkg::MAG_H:itrb_pkg::MAG_L];
			// Pre-signed copy saves the offset adder a negation
			dark_offset_value <= dof[itrb_pkg::DO_SGN] ? 7'h00 - mag_ext : mag_ext;
			smart_color_en <= sa[itrb_pkg::SA_EN];
			sat_floor_pct <= sa[itrb_pkg::SA_FLR] ? itrb_pkg::SAT_HI : itrb_pkg::SAT_LO;
			awb_chroma_min <= ch[itrb_pkg::CMIN_H:itrb_pkg::CMIN_L];
			awb_chroma_max <= ch[itrb_pkg::CMAX_H:itrb_pkg::CMAX_L];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_luma_delay: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_CL) |-> ##2 luma_delay_sel == $past(rx_reg[7:6], 2))
		else $error("luma delay select not taken from write");
	a_chroma_delay: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_CL) |-> ##2 chroma_delay_en == $past(rx_reg[4], 2))
		else $error("chroma delay enable not taken from write");
	a_chroma_avg: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_CL) |-> ##2 chroma_avg_en == $past(rx_reg[2], 2))
		else $error("chroma averaging not taken from write");
	a_color_kill: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_CL) |-> ##2 color_kill_level == $past(rx_reg[1:0], 2))
		else $error("colour kill level not taken from write");
	a_awb_region: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_WB) |-> ##2 awb_center_only == $past(rx_reg[6], 2))
		else $error("awb region not taken from write");
	a_awb_smart: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(wb[itrb_pkg::WB_SMART]) |-> ##1 awb_smart_en)
		else $error("smart awb enable late");
	a_awb_seed: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_WB) |-> ##2 awb_seed_en == $past(rx_reg[3], 2))
		else $error("awb seed not taken from write");
	a_agc_step: assert property (@(posedge clk) disable iff (!rst_n)
		agc_step_eighth == (agc_max_gain_db == itrb_pkg::G18))
		else $error("agc step does not match ceiling");
	a_agc_alias: assert property (@(posedge clk) disable iff (!rst_n)
		($past(wb[1:0]) == itrb_pkg::AG_6B) |-> agc_max_gain_db == itrb_pkg::G6)
		else $error("agc code 10 not 6dB");
	a_pump_ctrl: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_CP) |-> ##2
		{pump_en, pump_drive} == $past(rx_reg[7:4], 2))
		else $error("charge pump control not taken from write");
	a_vsync_drop: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_CP) |-> ##2 vsync_drop_suppress == $past(rx_reg[3], 2))
		else $error("vsync suppress not taken from write");
	a_dark_offset: assert property (@(posedge clk) disable iff (!rst_n)
		dark_offset_value == (dark_offset_neg ? 7'h00 - {1'b0, dark_offset_mag}
		: {1'b0, dark_offset_mag}))
		else $error("dark offset value disagrees with sign and magnitude");
	a_smart_color: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(sa[itrb_pkg::SA_EN]) |=> !smart_color_en)
		else $error("smart colour not cleared");
	a_sat_floor: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_SA) |-> ##2
		sat_floor_pct == ($past(rx_reg[5], 2) ? itrb_pkg::SAT_HI : itrb_pkg::SAT_LO))
		else $error("saturation floor wrong");
	a_chroma_limits: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_CH) |-> ##2
		{awb_chroma_min, awb_chroma_max} == $past(rx_reg[3:0], 2))
		else $error("chroma limits not taken from write");
	a_read_back: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && sub_reg == itrb_pkg::OFFS_R58) |=> bank[3] == $past(rx_reg))
		else $error("reserved byte does not hold written value");
	a_bank_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!wr_stb |=> $stable(bank[itrb_pkg::IX_DO]))
		else $error("register changed without a write");
endmodule // itrb_top

// ==== shared/itrb_pkg.sv ====
package itrb_pkg;
	localparam int NREG = 8;
	localparam logic [7:0] OFFS_CL = 8'h4F;
	localparam logic [7:0] OFFS_WB = 8'h54;
	localparam logic [7:0] OFFS_CP = 8'h57;
	localparam logic [7:0] OFFS_R58 = 8'h58;
	localparam logic [7:0] OFFS_DO = 8'h59;
	localparam logic [7:0] OFFS_SA = 8'h5A;
	localparam logic [7:0] OFFS_CH = 8'h5B;
	localparam logic [7:0] OFFS_R5C = 8'h5C;
	localparam logic [7:0] RST_CL = 8'h00;
	localparam logic [7:0] RST_WB = 8'h09;
	localparam logic [7:0] RST_CP = 8'h81;
	localparam logic [7:0] RST_R58 = 8'hF5;
	localparam logic [7:0] RST_DO = 8'h00;
	localparam logic [7:0] RST_SA = 8'h28;
	localparam logic [7:0] RST_CH = 8'h00;
	localparam logic [7:0] RST_R5C = 8'h13;
	localparam int IX_CL = 0;
	localparam int IX_WB = 1;
	localparam int IX_CP = 2;
	localparam int IX_DO = 4;
	localparam int IX_SA = 5;
	localparam int IX_CH = 6;
	localparam logic [7:0] REG_OFFS [NREG] = '{OFFS_CL, OFFS_WB, OFFS_CP, OFFS_R58,
		OFFS_DO, OFFS_SA, OFFS_CH, OFFS_R5C};
	localparam logic [7:0] REG_RST [NREG] = '{RST_CL, RST_WB, RST_CP, RST_R58,
		RST_DO, RST_SA, RST_CH, RST_R5C};
	// Field positions
	localparam int LY_H = 7;
	localparam int LY_L = 6;
	localparam int CL_UVD = 4;
	localparam int CL_AVG = 2;
	localparam int KL_H = 1;
	localparam int KL_L = 0;
	localparam int WB_CTR = 6;
	localparam int WB_SMART = 4;
	localparam int WB_SEED = 3;
	localparam int AG_H = 1;
	localparam int AG_L = 0;
	localparam int CP_EN = 7;
	localparam int DRV_H = 6;
	localparam int DRV_L = 4;
	localparam int CP_VS = 3;
	localparam int DO_SGN = 6;
	localparam int MAG_H = 5;
	localparam int MAG_L = 0;
	localparam int SA_EN = 6;
	localparam int SA_FLR = 5;
	localparam int CMIN_H = 3;
	localparam int CMIN_L = 2;
	localparam int CMAX_H = 1;
	localparam int CMAX_L = 0;
	localparam logic [1:0] AG_6A = 2'h0;
	localparam logic [1:0] AG_12 = 2'h1;
	localparam logic [1:0] AG_6B = 2'h2;
	localparam logic [4:0] G6 = 5'h06;
	localparam logic [4:0] G12 = 5'h0C;
	localparam logic [4:0] G18 = 5'h12;
	localparam logic [6:0] SAT_LO = 7'h28;
	localparam logic [6:0] SAT_HI = 7'h32;
	// Serial bus address, value is arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h2A;
	localparam logic [1:0] PIN_IDLE = 2'h3;
	localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage

// ==== test/itrb_host_model.sv ====
`timescale 1ns/100ps
module itrb_host_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	// Eight clocks per phase keeps well clear of the three-clock pin sampling delay
	localparam int PH = 8;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start_cond();
		sda_drv <= 1'b1;
		wait_clk(PH);
		scl <= 1'b1;
		wait_clk(PH);
		sda_drv <= 1'b0;
		wait_clk(PH);
		scl <= 1'b0;
		wait_clk(4);
	endtask
	task automatic stop_cond();
		sda_drv <= 1'b0;
		wait_clk(PH);
		scl <= 1'b1;
		wait_clk(PH);
		sda_drv <= 1'b1;
		wait_clk(PH);
	endtask
	// Data moves 4 clocks after scl falls so the device never sees it with the edge
	task automatic xfer_bit(input logic b, output logic r);
		sda_drv <= b;
		wait_clk(PH);
		scl <= 1'b1;
		wait_clk(PH / 2);
		r = sda;
		wait_clk(PH / 2);
		scl <= 1'b0;
		wait_clk(4);
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], r);
		end
		xfer_bit(1'b1, r);
		ack = ~r;
	endtask
	// Caller keeps reserved bits at their reset values
	task automatic write_burst(input logic [7:0] adr, input logic [7:0] offs, input int n,
		input logic [15:0] d, output logic ok);
		logic a;
		logic [15:0] s;
		start_cond();
		send_byte(adr, ok);
		send_byte(offs, a);
		ok = ok & a;
		for (int i = 0; i < n; i++) begin
			s = d >> (8 * (n - 1 - i));
			send_byte(s[7:0], a);
			ok = ok & a;
		end
		stop_cond();
	endtask
	task automatic read_burst(input logic [7:0] offs, input int n, output logic [15:0] d,
		output logic ok);
		logic a;
		logic r;
		d = 16'h0000;
		start_cond();
		send_byte({itrb_pkg::DEV_ADDR, 1'b0}, ok);
		send_byte(offs, a);
		ok = ok & a;
		start_cond();
		send_byte({itrb_pkg::DEV_ADDR, 1'b1}, a);
		ok = ok & a;
		for (int i = 0; i < n; i++) begin
			for (int j = 0; j < 8; j++) begin
				xfer_bit(1'b1, r);
				d = {d[14:0], r};
			end
			xfer_bit(i == n - 1, r);
		end
		stop_cond();
	endtask
endmodule // itrb_host_model

// ==== test/test_image_tuning_register_bank.sv ====
`timescale 1ns/100ps
module test_image_tuning_register_bank;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic scl, sda_drv, sda_w, sda_level, sda_oe, ok;
	logic [1:0] luma_delay_sel, color_kill_level, awb_chroma_min, awb_chroma_max;
	logic chroma_delay_en, chroma_avg_en, awb_center_only, awb_smart_en, awb_seed_en;
	logic agc_step_eighth, pump_en, vsync_drop_suppress, dark_offset_neg, smart_color_en;
	logic [4:0] agc_max_gain_db;
	logic [2:0] pump_drive;
	logic [5:0] dark_offset_mag;
	logic signed [6:0] dark_offset_value;
	logic [6:0] sat_floor_pct;
	logic [15:0] rd;
	logic [7:0] rst_tab [8] = '{8'h00, 8'h09, 8'h81, 8'hF5, 8'h00, 8'h28, 8'h00, 8'h13};
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #2 clk = ~clk;
	// Pull-up wire: low when either side pulls it
	assign sda_w = sda_drv & ~(sda_oe & ~sda_level);
	itrb_top DUT (.clk(clk), .rstn(rstn), .scl(scl), .sda(sda_w), .sda_level(sda_level),
		.sda_oe(sda_oe), .luma_delay_sel(luma_delay_sel), .chroma_delay_en(chroma_delay_en),
		.chroma_avg_en(chroma_avg_en), .color_kill_level(color_kill_level),
		.awb_center_only(awb_center_only), .awb_smart_en(awb_smart_en),
		.awb_seed_en(awb_seed_en), .agc_max_gain_db(agc_max_gain_db),
		.agc_step_eighth(agc_step_eighth), .pump_en(pump_en), .pump_drive(pump_drive),
		.vsync_drop_suppress(vsync_drop_suppress), .dark_offset_neg(dark_offset_neg),
		.dark_offset_mag(dark_offset_mag), .dark_offset_value(dark_offset_value),
		.smart_color_en(smart_color_en), .sat_floor_pct(sat_floor_pct),
		.awb_chroma_min(awb_chroma_min), .awb_chroma_max(awb_chroma_max));
	itrb_host_model host (.clk(clk), .sda(sda_w), .scl(scl), .sda_drv(sda_drv));
	////////////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("comparisons %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask
	task automatic wr_rd(input logic [7:0] offs, input logic [7:0] v);
		host.write_burst({itrb_pkg::DEV_ADDR, 1'b0}, offs, 1, 16'(v), ok);
		chk(16'(ok), 16'h0001);
		host.read_burst(offs, 1, rd, ok);
		chk(rd, 16'(v));
	endtask
	////////////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		for (int k = 0; k < 8; k++) begin
			host.read_burst(itrb_pkg::REG_OFFS[k], 1, rd, ok);
			chk(rd, 16'(rst_tab[k]));
		end
		chk(16'(agc_max_gain_db), 16'h000C);
		chk(16'({awb_seed_en, pump_en, pump_drive}), 16'h0018);
		chk(16'(sat_floor_pct), 16'h0032);
		chk(16'({luma_delay_sel, chroma_delay_en, color_kill_level}), 16'h0000);
	endtask
	task automatic test_tuning();
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr_rd(8'h4F, {c, 1'b0, c[0], 1'b0, c[1], ~c});
			chk(16'(luma_delay_sel), 16'(c));
			chk(16'({chroma_delay_en, chroma_avg_en}), 16'({c[0], c[1]}));
			chk(16'(color_kill_level), {14'h0000, ~c});
		end
	endtask
	task automatic test_gain();
		logic [1:0] c;
		logic [4:0] g;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			g = (c == 2'h1) ? 5'h0C : (c == 2'h3) ? 5'h12 : 5'h06;
			wr_rd(8'h54, {1'b0, c[0], 1'b0, c[1], ~c[0], 1'b0, c});
			chk(16'({awb_center_only, awb_smart_en}), 16'({c[0], c[1]}));
			chk(16'(awb_seed_en), {15'h0000, ~c[0]});
			chk(16'({agc_max_gain_db, agc_step_eighth}), 16'({g, c == 2'h3}));
		end
	endtask
	task automatic test_pump();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			wr_rd(8'h57, {c[0], c, ~c[1], 3'h1});
			chk(16'({pump_en, pump_drive}), 16'({c[0], c}));
			chk(16'(vsync_drop_suppress), {15'h0000, ~c[1]});
		end
	endtask
	// Two-byte bursts cross the sub-address auto-increment
	task automatic test_dark_sat();
		host.write_burst({itrb_pkg::DEV_ADDR, 1'b0}, 8'h59, 2, 16'h4548, ok);
		chk(16'({dark_offset_neg, dark_offset_mag}), 16'h0045);
		// Zero-filled on purpose: a signed cast would sign-extend the negative offset
		chk({9'h000, dark_offset_value}, 16'h007B);
		chk(16'({smart_color_en, sat_floor_pct}), 16'h00A8);
		host.read_burst(8'h59, 2, rd, ok);
		chk(rd, 16'h4548);
		host.write_burst({itrb_pkg::DEV_ADDR, 1'b0}, 8'h59, 2, 16'h3F28, ok);
		chk({9'h000, dark_offset_value}, 16'h003F);
		chk(16'({smart_color_en, sat_floor_pct}), 16'h0032);
	endtask
	task automatic test_limits();
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr_rd(8'h5B, {4'h0, c, ~c});
			chk(16'({awb_chroma_min, awb_chroma_max}), 16'({c, ~c}));
		end
	endtask
	// Foreign address is refused; unmapped offset is acked but reads zero
	task automatic test_refuse();
		host.write_burst({itrb_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 8'h4F, 1, 16'h0000, ok);
		chk(16'(ok), 16'h0000);
		chk(16'(luma_delay_sel), 16'h0003);
		host.write_burst({itrb_pkg::DEV_ADDR, 1'b0}, 8'h50, 1, 16'h0055, ok);
		chk(16'(ok), 16'h0001);
		host.read_burst(8'h50, 1, rd, ok);
		chk(rd, 16'h0000);
		wr_rd(8'h58, 8'hF5);
		wr_rd(8'h5C, 8'h13);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		test_reset();
		test_tuning();
		test_gain();
		test_pump();
		test_dark_sat();
		test_limits();
		test_refuse();
		give_verdict();
	end
endmodule // test_image_tuning_register_bank
